// *** cbu_map.svh ***
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

// ****************************************
// status flag bit positions
// ****************************************
`define CBU_FLAG_C 3'h0
`define CBU_FLAG_Z 3'h1
`define CBU_FLAG_N 3'h2
`define CBU_FLAG_V 3'h3
`define CBU_FLAG_S 3'h4
`define CBU_FLAG_H 3'h5
`define CBU_FLAG_T 3'h6
`define CBU_FLAG_I 3'h7

// ****************************************
// reset values
// ****************************************
`define CBU_PC_RST    16'h0000
`define CBU_FLAGS_RST 8'h00

// ****************************************
// cycle counts per outcome
// ****************************************
`define CBU_CYC_NOT_TAKEN 2'h1
`define CBU_CYC_TAKEN     2'h2

`endif

// *** cbu_pkg.sv ***
package cbu_pkg;

   // ****************************************
   // instruction kinds seen by the unit
   // ****************************************
   typedef enum logic [4:0] {
      cbu_k_none                        = 5'h00,
      cbu_k_branch_on_flag_clear        = 5'h01,
      cbu_k_branch_on_flag_set          = 5'h02,
      cbu_k_branch_equal                = 5'h03,
      cbu_k_branch_not_equal            = 5'h04,
      cbu_k_branch_carry_set            = 5'h05,
      cbu_k_branch_carry_clear          = 5'h06,
      cbu_k_branch_same_or_higher       = 5'h07,
      cbu_k_branch_lower                = 5'h08,
      cbu_k_branch_minus                = 5'h09,
      cbu_k_branch_plus                 = 5'h0a,
      cbu_k_branch_greater_equal_signed = 5'h0b,
      cbu_k_branch_less_signed          = 5'h0c,
      cbu_k_branch_half_carry_set       = 5'h0d,
      cbu_k_branch_half_carry_clear     = 5'h0e,
      cbu_k_branch_transfer_set         = 5'h0f,
      cbu_k_branch_transfer_clear       = 5'h10
   } cbu_kind_t;

   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic {
      cbu_s_exec  = 1'b0,
      cbu_s_flush = 1'b1
   } cbu_state_t;

endpackage

// *** cbu_cond_eval.sv ***
`timescale 1ns/1ps
`include "cbu_map.svh"

module cbu_cond_eval (
   input  wire logic              [4:0] kind,
   input  wire logic              [7:0] flags,
   input  wire logic              [2:0] index,
   output      logic                    take
);

   logic nv;

   always_comb begin
      nv   = flags[`CBU_FLAG_N] ^ flags[`CBU_FLAG_V];
      take = 1'b0;
      case (kind)
         cbu_pkg::cbu_k_branch_on_flag_clear:        take = ~flags[index];
         cbu_pkg::cbu_k_branch_on_flag_set:          take = flags[index];
         cbu_pkg::cbu_k_branch_equal:                take = flags[`CBU_FLAG_Z];
         cbu_pkg::cbu_k_branch_not_equal:            take = ~flags[`CBU_FLAG_Z];
         cbu_pkg::cbu_k_branch_carry_set,
         cbu_pkg::cbu_k_branch_lower:                take = flags[`CBU_FLAG_C];
         cbu_pkg::cbu_k_branch_carry_clear,
         cbu_pkg::cbu_k_branch_same_or_higher:       take = ~flags[`CBU_FLAG_C];
         cbu_pkg::cbu_k_branch_minus:                take = flags[`CBU_FLAG_N];
         cbu_pkg::cbu_k_branch_plus:                 take = ~flags[`CBU_FLAG_N];
         cbu_pkg::cbu_k_branch_greater_equal_signed: take = ~nv;
         cbu_pkg::cbu_k_branch_less_signed:          take = nv;
         cbu_pkg::cbu_k_branch_half_carry_set:       take = flags[`CBU_FLAG_H];
         cbu_pkg::cbu_k_branch_half_carry_clear:     take = ~flags[`CBU_FLAG_H];
         cbu_pkg::cbu_k_branch_transfer_set:         take = flags[`CBU_FLAG_T];
         cbu_pkg::cbu_k_branch_transfer_clear:       take = ~flags[`CBU_FLAG_T];
         default:                                    take = 1'b0;
      endcase
   end

endmodule

// *** cbu_target_add.sv ***
`timescale 1ns/1ps

module cbu_target_add #(
   parameter int PC_W  = 16,
   parameter int OFF_W = 7
) (
   input  wire logic [PC_W-1:0]  pc,
   input  wire logic [OFF_W-1:0] offset,
   output      logic [PC_W-1:0]  target
);

   logic [PC_W-1:0] off_ext;

   always_comb begin
      // signed word offset, reaches back and forward
      off_ext = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset};
      target  = pc + off_ext + PC_W'(1);
   end

endmodule

// *** cbu_branch_unit.sv ***
`timescale 1ns/1ps
`include "cbu_map.svh"

module cbu_branch_unit #(
   parameter int PC_W  = 16,
   parameter int OFF_W = 7
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              clk_en,
   input  wire logic              in_valid,
   input  wire logic [4:0]        in_kind,
   input  wire logic [2:0]        in_index,
   input  wire logic [OFF_W-1:0]  in_offset,
   output      logic              in_ready,
   input  wire logic              flag_we,
   input  wire logic [7:0]        flag_wdata,
   output      logic [7:0]        status_flags,
   output      logic [PC_W-1:0]   pc,
   output      logic              discard,
   output      logic              taken,
   output      logic              done,
   output      logic [1:0]        cycles
);

   // ****************************************
   // state
   // ****************************************
   cbu_pkg::cbu_state_t state_reg;
   cbu_pkg::cbu_state_t state_next;
   logic [PC_W-1:0]     pc_reg;
   logic [PC_W-1:0]     pc_next;
   logic [7:0]          status_flags_reg;
   logic [7:0]          status_flags_next;
   logic                taken_reg;
   logic                taken_next;
   logic                done_reg;
   logic                done_next;
   logic [1:0]          cycles_reg;
   logic [1:0]          cycles_next;

   logic                accept;
   logic                is_branch;
   logic                cond_true;
   logic [PC_W-1:0]     target;
   logic                jump_go;
   logic                step_go;

   // ****************************************
   // condition and target
   // ****************************************
   cbu_cond_eval u_cond (
      .kind  (in_kind),
      .flags (status_flags_reg),
      .index (in_index),
      .take  (cond_true)
   );

   cbu_target_add #(
      .PC_W  (PC_W),
      .OFF_W (OFF_W)
   ) u_add (
      .pc     (pc_reg),
      .offset (in_offset),
      .target (target)
   );

   // ****************************************
   // handshake
   // ****************************************
   always_comb begin
      in_ready  = (state_reg == cbu_pkg::cbu_s_exec);
      discard   = (state_reg == cbu_pkg::cbu_s_flush);
      accept    = in_valid && in_ready;
      is_branch = (in_kind != cbu_pkg::cbu_k_none);
      jump_go   = accept && is_branch && cond_true;
      step_go   = accept && !jump_go;
   end

   // ****************************************
   // sequencer next value
   // ****************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         cbu_pkg::cbu_s_exec: begin
            if (jump_go) begin
               state_next = cbu_pkg::cbu_s_flush;
            end
         end
         cbu_pkg::cbu_s_flush: begin
            // fall-through fetch is dropped here
            state_next = cbu_pkg::cbu_s_exec;
         end
      endcase
   end

   // ****************************************
   // sequencer register
   // ****************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= cbu_pkg::cbu_s_exec;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // program counter next value
   // ****************************************
   always_comb begin
      pc_next = pc_reg;
      if (jump_go) begin
         pc_next = target;
      end else if (step_go) begin
         pc_next = pc_reg + PC_W'(1);
      end
   end

   // ****************************************
   // program counter register
   // ****************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pc_reg <= PC_W'(`CBU_PC_RST);
      end else if (clk_en) begin
         pc_reg <= pc_next;
      end
   end

   // ****************************************
   // status flags next value
   // ****************************************
   always_comb begin
      status_flags_next = status_flags_reg;
      // only the flag write port changes flags
      if (flag_we) begin
         status_flags_next = flag_wdata;
      end
   end

   // ****************************************
   // status flags register
   // ****************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_flags_reg <= `CBU_FLAGS_RST;
      end else if (clk_en) begin
         status_flags_reg <= status_flags_next;
      end
   end

   // ****************************************
   // taken pulse next value
   // ****************************************
   always_comb begin
      // pulse for the cycle after a taken accept
      taken_next = jump_go;
   end

   // ****************************************
   // taken pulse register
   // ****************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         taken_reg <= 1'b0;
      end else if (clk_en) begin
         taken_reg <= taken_next;
      end
   end

   // ****************************************
   // done pulse next value
   // ****************************************
   always_comb begin
      done_next = 1'b0;
      if (step_go) begin
         // plain instructions finish without a report
         done_next = is_branch;
      end else if (discard) begin
         done_next = 1'b1;
      end
   end

   // ****************************************
   // done pulse register
   // ****************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         done_reg <= 1'b0;
      end else if (clk_en) begin
         done_reg <= done_next;
      end
   end

   // ****************************************
   // cycle count next value
   // ****************************************
   always_comb begin
      cycles_next = cycles_reg;
      if (step_go && is_branch) begin
         cycles_next = `CBU_CYC_NOT_TAKEN;
      end else if (discard) begin
         cycles_next = `CBU_CYC_TAKEN;
      end
   end

   // ****************************************
   // cycle count register
   // ****************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cycles_reg <= 2'h0;
      end else if (clk_en) begin
         cycles_reg <= cycles_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_comb begin
      status_flags = status_flags_reg;
      pc           = pc_reg;
      taken        = taken_reg;
      done         = done_reg;
      cycles       = cycles_reg;
   end

endmodule

// *** cbu_branch_unit_monitor.sv ***
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module cbu_branch_monitor #(
   parameter int PC_W  = 16,
   parameter int OFF_W = 7
) (
   input wire logic             clock,
   input wire logic             nrst,
   input wire logic             clk_en,
   input wire logic             in_valid,
   input wire logic [4:0]       in_kind,
   input wire logic [2:0]       in_index,
   input wire logic [OFF_W-1:0] in_offset,
   input wire logic             in_ready,
   input wire logic             flag_we,
   input wire logic [7:0]       flag_wdata,
   input wire logic [7:0]       status_flags,
   input wire logic [PC_W-1:0]  pc,
   input wire logic             discard,
   input wire logic             taken,
   input wire logic             done,
   input wire logic [1:0]       cycles
);
   wire            acc = clk_en && in_valid && in_ready;
   wire [PC_W-1:0] tgt = pc + {{(PC_W-OFF_W){in_offset[OFF_W-1]}}, in_offset} + PC_W'(1);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_flush;
      discard && !in_ready && !done ##1 done && cycles == 2'h2 && !discard;
   endsequence
   AST_FLUSH: assert property (taken && clk_en |-> s_flush)
      else $error("taken branch flush wrong");
   AST_PC: assert property (acc |=> (taken && pc == $past(tgt))
      || (!taken && pc == $past(pc) + 1'b1)) else $error("pc update wrong");
   AST_SHORT: assert property (acc && in_kind != 5'h00 |=> taken
      || (done && cycles == 2'h1)) else $error("not taken branch timing wrong");
   AST_HOLD: assert property (clk_en && !flag_we |=> $stable(status_flags))
      else $error("flags changed");
   AST_EQ: assert property (acc && in_kind == 5'h03 && !status_flags[1] |=> !taken)
      else $error("equal branch wrong");
   AST_NE: assert property (acc && in_kind == 5'h04 && status_flags[1] |=> !taken)
      else $error("not equal branch wrong");
   AST_SET: assert property (acc && in_kind == 5'h02 && status_flags[in_index] |=> taken)
      else $error("flag set branch wrong");
   AST_CLR: assert property (acc && in_kind == 5'h01 && status_flags[in_index] |=> !taken)
      else $error("flag clear branch wrong");
   AST_GE: assert property (acc && in_kind == 5'h0b
      && (status_flags[2] ^ status_flags[3]) |=> !taken) else $error("signed ge wrong");
endmodule

bind cbu_branch_unit cbu_branch_monitor #(.PC_W(PC_W), .OFF_W(OFF_W)) i_monitor (
   .clock(clock), .nrst(nrst), .clk_en(clk_en), .in_valid(in_valid), .in_kind(in_kind),
   .in_index(in_index), .in_offset(in_offset), .in_ready(in_ready), .flag_we(flag_we),
   .flag_wdata(flag_wdata), .status_flags(status_flags), .pc(pc), .discard(discard),
   .taken(taken), .done(done), .cycles(cycles)
);

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [4:0] k;
      logic [7:0] f;
      logic [2:0] i;
      logic [6:0] o;
      logic       e;
   } cbu_row_t;
   logic        clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, in_valid = 1'b0, flag_we = 1'b0;
   logic [4:0]  in_kind = 5'h00;
   logic [2:0]  in_index = 3'h0;
   logic [6:0]  in_offset = 7'h00;
   logic [7:0]  flag_wdata = 8'h00, status_flags;
   logic [15:0] pc, model_pc = 16'h0000;
   logic [1:0]  cycles;
   logic        in_ready, discard, taken, done;
   int          miscompares = 0, check_count = 0, cyc = 0;
   cbu_row_t    rows [23] = '{
      '{5'h01,8'hfb,3'h2,7'h05,1'b1}, '{5'h01,8'h04,3'h2,7'h3f,1'b0},
      '{5'h02,8'h80,3'h7,7'h40,1'b1}, '{5'h02,8'h7f,3'h7,7'h00,1'b0},
      '{5'h03,8'h02,3'h0,7'h7e,1'b1}, '{5'h03,8'hfd,3'h0,7'h01,1'b0},
      '{5'h04,8'hfd,3'h0,7'h3f,1'b1}, '{5'h04,8'h02,3'h0,7'h00,1'b0},
      '{5'h05,8'h01,3'h0,7'h01,1'b1}, '{5'h08,8'h01,3'h0,7'h7f,1'b1},
      '{5'h06,8'hfe,3'h0,7'h02,1'b1}, '{5'h07,8'h01,3'h0,7'h02,1'b0},
      '{5'h09,8'h04,3'h0,7'h03,1'b1}, '{5'h0a,8'h04,3'h0,7'h03,1'b0},
      '{5'h0b,8'h0c,3'h0,7'h04,1'b1}, '{5'h0b,8'h04,3'h0,7'h04,1'b0},
      '{5'h0c,8'h08,3'h0,7'h05,1'b1}, '{5'h0c,8'h0c,3'h0,7'h05,1'b0},
      '{5'h0d,8'h20,3'h0,7'h06,1'b1}, '{5'h0e,8'h20,3'h0,7'h06,1'b0},
      '{5'h0f,8'h40,3'h0,7'h07,1'b1}, '{5'h10,8'h40,3'h0,7'h07,1'b0},
      '{5'h11,8'hff,3'h0,7'h05,1'b0}};

   cbu_branch_unit i_cbu_branch_unit (
      .clock(clock), .nrst(nrst), .clk_en(clk_en), .in_valid(in_valid), .in_kind(in_kind),
      .in_index(in_index), .in_offset(in_offset), .in_ready(in_ready), .flag_we(flag_we),
      .flag_wdata(flag_wdata), .status_flags(status_flags), .pc(pc), .discard(discard),
      .taken(taken), .done(done), .cycles(cycles)
   );

   always #50 clock = ~clock;

   // ********************
   // checking helpers
   // ********************
   task automatic test_done;
      if (miscompares == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 1000) begin
         miscompares++;
         test_done;
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic chk_rst;
      chk("pc", 16'h0000, pc);
      chk("flags", 16'h0000, status_flags);
      chk("cycles", 16'h0000, cycles);
      chk("ready", 16'h0001, in_ready);
      chk("taken", 16'h0000, taken);
      chk("done", 16'h0000, done);
      chk("discard", 16'h0000, discard);
   endtask

   task automatic run(input cbu_row_t r);
      logic [15:0] exp_pc;
      exp_pc = model_pc + 16'h0001 + (r.e ? {{9{r.o[6]}}, r.o} : 16'h0000);
      @(posedge clock);
      flag_we <= 1'b1;
      flag_wdata <= r.f;
      @(posedge clock);
      flag_we <= 1'b0;
      in_valid <= 1'b1;
      {in_kind, in_index, in_offset} <= {r.k, r.i, r.o};
      @(posedge clock);
      in_valid <= 1'b0;
      #1;
      chk("taken", r.e, taken);
      chk("pc", exp_pc, pc);
      if (r.e) begin
         chk("ready", 16'h0000, in_ready);
         chk("discard", 16'h0001, discard);
         @(posedge clock);
         #1;
      end
      chk("discard", 16'h0000, discard);
      chk("done", 16'h0001, done);
      chk("cycles", r.e ? 16'h0002 : 16'h0001, cycles);
      chk("flags", r.f, status_flags);
      model_pc = exp_pc;
   endtask

   // ********************
   // main sequence
   // ********************
   initial begin
      repeat (20) @(posedge clock);
      #1;
      chk_rst;
      @(posedge clock);
      nrst <= 1'b1;
      foreach (rows[n]) run(rows[n]);
      // request held through the flush cycle must be ignored there
      run('{5'h03,8'h02,3'h0,7'h02,1'b1});
      @(posedge clock);
      in_valid <= 1'b1;
      in_kind <= 5'h03;
      @(posedge clock);
      in_kind <= 5'h00;
      @(posedge clock);
      #1;
      chk("pc", model_pc + 16'h0003, pc);
      chk("cycles", 16'h0002, cycles);
      @(posedge clock);
      in_valid <= 1'b0;
      #1;
      chk("pc", model_pc + 16'h0004, pc);
      chk("done", 16'h0000, done);
      // reset right behind a taken branch, then a clean restart
      @(posedge clock);
      flag_we <= 1'b1;
      flag_wdata <= 8'h02;
      @(posedge clock);
      flag_we <= 1'b0;
      in_valid <= 1'b1;
      in_kind <= 5'h03;
      @(posedge clock);
      in_valid <= 1'b0;
      #1;
      chk("discard", 16'h0001, discard);
      @(posedge clock);
      nrst <= 1'b0;
      @(posedge clock);
      #1;
      chk_rst;
      @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      #1;
      chk_rst;
      model_pc = 16'h0000;
      run(rows[4]);
      // a low enable holds the flush cycle and ignores flag writes
      @(posedge clock);
      in_valid <= 1'b1;
      in_offset <= 7'h01;
      @(posedge clock);
      in_valid <= 1'b0;
      clk_en <= 1'b0;
      flag_we <= 1'b1;
      flag_wdata <= 8'hff;
      repeat (2) @(posedge clock);
      #1;
      chk("taken", 16'h0001, taken);
      chk("discard", 16'h0001, discard);
      chk("done", 16'h0000, done);
      chk("pc", model_pc + 16'h0002, pc);
      @(posedge clock);
      clk_en <= 1'b1;
      flag_we <= 1'b0;
      @(posedge clock);
      #1;
      chk("done", 16'h0001, done);
      chk("cycles", 16'h0002, cycles);
      chk("flags", 16'h0002, status_flags);
      test_done;
   end
endmodule
